// *** pkg/csc_pkg.sv ***
package csc_pkg;
  // Temperatures are signed, 0.5 K per LSB is not assumed: whole degrees C
  localparam int TEMP_W = 10;
  localparam int DUTY_W = 7;
  localparam int MIN_W = 11;
  localparam int NWIN = 5;
  localparam int NDAY = 7;
  localparam int CLK_HZ = 250_000_000;
  localparam int TAP_MAX_S = 5;
  localparam int TAP_MAX_CYC = TAP_MAX_S * CLK_HZ;
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;
  localparam logic [DUTY_W-1:0] PUMP_DUTY_RST = 7'h28;
  localparam logic [TEMP_W-1:0] CIRC_ON_RST = 10'h037;
  localparam logic [TEMP_W-1:0] CIRC_DOFF_RST = 10'h002;
  localparam logic [TEMP_W-1:0] CIRC_DOFF_MIN = 10'h002;
  localparam logic [TEMP_W-1:0] CIRC_DOFF_MAX = 10'h00A;
  localparam logic [MIN_W-1:0] RUN_SEC_RST = 11'h03C;
  localparam logic [MIN_W-1:0] RUN_SEC_MAX = 11'h258;
  localparam logic [MIN_W-1:0] PAUSE_MIN_RST = 11'h00A;
  localparam logic [MIN_W-1:0] PAUSE_MIN_MAX = 11'h03C;
  localparam logic [TEMP_W-1:0] STRAT_DON_MIN = 10'h001;
  localparam logic [TEMP_W-1:0] STRAT_DON_MAX = 10'h014;
  localparam logic [TEMP_W-1:0] STRAT_DON_RST = 10'h00A;
  localparam logic [5:0] SEC_PER_MIN = 6'h3C;
  typedef enum logic [1:0] {
    CSC_IDLE = 2'b00,
    CSC_RUN = 2'b01,
    CSC_PAUSE = 2'b10
  } csc_dem_t;
endpackage : csc_pkg

// *** hdl/csc_tap_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module csc_tap_det
  import csc_pkg::*;
#(
  parameter int TAP_CYC = TAP_MAX_CYC
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic flow_i,
  output logic tap_o
);
  logic [31:0] cnt_r;
  logic flow_r;
  logic long_r;
  // Open time is counted; a flow longer than the limit is a real draw, not an impulse
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 32'h0;
      flow_r <= 1'b0;
      long_r <= 1'b0;
    end else begin
      flow_r <= flow_i;
      if (!flow_i) begin
        cnt_r <= 32'h0;
        long_r <= 1'b0;
      end else if (cnt_r >= 32'(TAP_CYC)) begin
        long_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tap_o <= 1'b0;
    end else begin
      tap_o <= flow_r && !flow_i && !long_r;
    end
  end
endmodule : csc_tap_det
`default_nettype wire

// *** hdl/csc_win_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module csc_win_mem
  import csc_pkg::*;
(
  input wire logic clock_i,
  input wire logic wr_i,
  input wire logic [5:0] waddr_i,
  input wire logic [21:0] wdata_i,
  input wire logic [5:0] raddr_i,
  output logic [21:0] rdata_o
);
  // Entry: valid, start minute, stop minute; index = day*8 + window
  logic [21:0] mem [0:63];
  always_ff @(posedge clock_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : csc_win_mem
`default_nettype wire

// *** hdl/csc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Circulation pump PWM output carries configured duty, 0 to 100 percent.
// - Temperature, time and demand modes enable independently, any combination.
// - Temperature input is cold water or selected external sensor, cold water default.
// - Pump on when selected temperature falls below switch-on temperature.
// - Pump off above switch-on plus switch-off delta, delta clamped 2 to 10 K.
// - Continuous operation with time mode on keeps the pump running permanently.
// - Pump runs inside a time window; five windows per weekday.
// - Flow open at most five seconds then closed is a tap impulse.
// - Tap impulse in demand mode runs pump for the configured runtime.
// - After the runtime the pump is locked for the pause duration.
// - New impulses ignored during runtime and pause.
// - Changed settings applied only after the cycle and pause end; a load during them is dropped, not held.
// - Temperature plus time: temperature rules inside windows, off outside.
// - Temperature plus demand: stop at threshold or runtime end, then pause.
// - Time plus demand: continuous in windows, demand runs outside.
// - All three: temperature inside windows, demand outside, early end still pauses.
// - Master and mode enables default off after reset.
// - Thermostat mode energises relay when return exceeds switch-on temperature.
// - Thermostat mode releases relay below switch-on minus hysteresis.
// - Differential mode takes tank temperature from the storage tank input only.
// - Differential mode energises when return minus tank exceeds on delta.
// - Differential mode releases when the difference falls below off delta.
// - External return sensor may replace cold water sensor in both modes.
// - Stratification drives relay one or two, relay two by default.
// - Switch-on delta clamped 1 to 20 K, taken straight from the input.
module csc_ctrl
  import csc_pkg::*;
#(
  parameter int TAP_CYC = TAP_MAX_CYC,
  parameter int SEC_CYCLES = SEC_CYC
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic signed [TEMP_W-1:0] cold_water_temp_i,
  input wire logic signed [TEMP_W-1:0] aux_sensor_input_i,
  input wire logic signed [TEMP_W-1:0] storage_tank_sensor_input_i,
  input wire logic flow_detect_i,
  input wire logic [10:0] minute_of_day_i,
  input wire logic [2:0] weekday_i,
  input wire logic circ_enable_i,
  input wire logic temp_mode_en_i,
  input wire logic time_mode_en_i,
  input wire logic continuous_i,
  input wire logic demand_mode_en_i,
  input wire logic circ_ext_sel_i,
  input wire logic [TEMP_W-1:0] circ_on_temp_i,
  input wire logic [TEMP_W-1:0] circ_off_delta_i,
  input wire logic [MIN_W-1:0] run_sec_i,
  input wire logic [MIN_W-1:0] pause_min_i,
  input wire logic [DUTY_W-1:0] pump_duty_i,
  input wire logic settings_load_i,
  input wire logic win_wr_i,
  input wire logic [5:0] win_addr_i,
  input wire logic [21:0] win_data_i,
  input wire logic strat_enable_i,
  input wire logic strat_diff_mode_i,
  input wire logic strat_ext_sel_i,
  input wire logic strat_relay1_sel_i,
  input wire logic [TEMP_W-1:0] strat_on_temp_i,
  input wire logic [TEMP_W-1:0] strat_hyst_i,
  input wire logic [TEMP_W-1:0] strat_on_delta_i,
  input wire logic [TEMP_W-1:0] strat_off_delta_i,
  output logic [DUTY_W-1:0] circ_pwm_duty_o,
  output logic relay1_o,
  output logic relay2_o,
  output logic [1:0] demand_state_o
);
  // Active settings, reloaded only when the demand logic is idle, neither running nor paused
  logic act_en_r, act_temp_r, act_time_r, act_cont_r, act_dem_r, act_ext_r;
  logic [TEMP_W-1:0] act_on_r, act_doff_r;
  logic [MIN_W-1:0] act_run_r, act_pause_r;
  logic [DUTY_W-1:0] act_duty_r;
  csc_dem_t dem_r;
  logic tap;
  logic [21:0] win_rd;
  logic [5:0] scan_addr_r;
  logic [2:0] scan_idx_r;
  logic scan_hit_r, in_win_r, rd_valid_r;
  logic temp_on_r;
  logic [31:0] sec_cnt_r;
  logic [MIN_W+5:0] dem_sec_r;
  logic signed [TEMP_W:0] circ_t, on_t, off_t;
  logic temp_call, want_pump;
  csc_tap_det #(.TAP_CYC(TAP_CYC)) u_tap (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .flow_i(flow_detect_i),
    .tap_o(tap)
  );
  csc_win_mem u_win (
    .clock_i(clock_i),
    .wr_i(win_wr_i),
    .waddr_i(win_addr_i),
    .wdata_i(win_data_i),
    .raddr_i(scan_addr_r),
    .rdata_o(win_rd)
  );
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_en_r <= 1'b0;
      act_temp_r <= 1'b0;
      act_time_r <= 1'b0;
      act_cont_r <= 1'b0;
      act_dem_r <= 1'b0;
      act_ext_r <= 1'b0;
      act_on_r <= CIRC_ON_RST;
      act_doff_r <= CIRC_DOFF_RST;
      act_run_r <= RUN_SEC_RST;
      act_pause_r <= PAUSE_MIN_RST;
      act_duty_r <= PUMP_DUTY_RST;
    end else if (settings_load_i && dem_r == CSC_IDLE) begin
      act_en_r <= circ_enable_i;
      act_temp_r <= temp_mode_en_i;
      act_time_r <= time_mode_en_i;
      act_cont_r <= continuous_i;
      act_dem_r <= demand_mode_en_i;
      act_ext_r <= circ_ext_sel_i;
      act_on_r <= circ_on_temp_i;
      act_doff_r <= (circ_off_delta_i < CIRC_DOFF_MIN) ? CIRC_DOFF_MIN :
                    (circ_off_delta_i > CIRC_DOFF_MAX) ? CIRC_DOFF_MAX : circ_off_delta_i;
      act_run_r <= (run_sec_i > RUN_SEC_MAX) ? RUN_SEC_MAX : run_sec_i;
      act_pause_r <= (pause_min_i > PAUSE_MIN_MAX) ? PAUSE_MIN_MAX : pause_min_i;
      act_duty_r <= (pump_duty_i > DUTY_FULL) ? DUTY_FULL : pump_duty_i;
    end
  end
  // Window scan walks the day's five entries; result lags time by a few cycles
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scan_idx_r <= 3'h0;
      scan_addr_r <= 6'h00;
      rd_valid_r <= 1'b0;
      scan_hit_r <= 1'b0;
      in_win_r <= 1'b0;
    end else begin
      scan_idx_r <= (scan_idx_r == 3'(NWIN - 1)) ? 3'h0 : scan_idx_r + 3'h1;
      scan_addr_r <= {weekday_i, scan_idx_r};
      rd_valid_r <= 1'b1;
      if (rd_valid_r && win_rd[21] && minute_of_day_i >= win_rd[20:10]
          && minute_of_day_i < {1'b0, win_rd[9:0]}) begin
        scan_hit_r <= 1'b1;
      end else if (scan_addr_r[2:0] == 3'h0) begin
        scan_hit_r <= 1'b0;
      end
      if (scan_addr_r[2:0] == 3'h0) begin
        in_win_r <= scan_hit_r;
      end
    end
  end
  assign circ_t = act_ext_r ? {aux_sensor_input_i[TEMP_W-1], aux_sensor_input_i}
                            : {cold_water_temp_i[TEMP_W-1], cold_water_temp_i};
  assign on_t = {1'b0, act_on_r};
  assign off_t = on_t + {1'b0, act_doff_r};
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_on_r <= 1'b0;
    end else if (circ_t < on_t) begin
      temp_on_r <= 1'b1;
    end else if (circ_t > off_t) begin
      temp_on_r <= 1'b0;
    end
  end
  // Demand only acts outside windows when time control is on
  logic dem_allowed;
  assign dem_allowed = act_en_r && act_dem_r && !(act_time_r && (act_cont_r || in_win_r));
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dem_r <= CSC_IDLE;
      sec_cnt_r <= 32'h0;
      dem_sec_r <= '0;
    end else begin
      sec_cnt_r <= (sec_cnt_r >= 32'(SEC_CYCLES - 1)) ? 32'h0 : sec_cnt_r + 32'h1;
      case (dem_r)
        CSC_IDLE: begin
          if (tap && dem_allowed) begin
            dem_r <= CSC_RUN;
            sec_cnt_r <= 32'h0;
            dem_sec_r <= {6'h00, act_run_r};
          end
        end
        CSC_RUN: begin
          if (dem_sec_r == '0 || (act_temp_r && circ_t > off_t)) begin
            dem_r <= CSC_PAUSE;
            sec_cnt_r <= 32'h0;
            // Widen before the product: an hour of seconds does not fit in eleven bits
            dem_sec_r <= 17'(act_pause_r) * 17'(SEC_PER_MIN);
          end else if (sec_cnt_r >= 32'(SEC_CYCLES - 1)) begin
            dem_sec_r <= dem_sec_r - 17'h1;
          end
        end
        CSC_PAUSE: begin
          if (dem_sec_r == '0) begin
            dem_r <= CSC_IDLE;
          end else if (sec_cnt_r >= 32'(SEC_CYCLES - 1)) begin
            dem_sec_r <= dem_sec_r - 17'h1;
          end
        end
        default: dem_r <= CSC_IDLE;
      endcase
    end
  end
  assign demand_state_o = dem_r;
  always_comb begin
    temp_call = act_temp_r && temp_on_r;
    if (!act_en_r) begin
      want_pump = 1'b0;
    end else if (act_time_r && act_cont_r) begin
      want_pump = 1'b1;
    end else if (act_time_r && in_win_r) begin
      want_pump = act_temp_r ? temp_on_r : 1'b1;
    end else if (dem_r == CSC_RUN) begin
      want_pump = 1'b1;
    end else if (act_time_r || act_dem_r) begin
      want_pump = 1'b0;
    end else begin
      want_pump = temp_call;
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      circ_pwm_duty_o <= '0;
    end else begin
      circ_pwm_duty_o <= want_pump ? act_duty_r : '0;
    end
  end
  // Stratification valve
  logic signed [TEMP_W:0] ret_t, tank_t, diff_t, s_on_t, s_hys_t, s_don_t;
  logic [TEMP_W-1:0] don_clamped;
  logic strat_r;
  assign don_clamped = (strat_on_delta_i < STRAT_DON_MIN) ? STRAT_DON_MIN :
                       (strat_on_delta_i > STRAT_DON_MAX) ? STRAT_DON_MAX : strat_on_delta_i;
  assign ret_t = strat_ext_sel_i ? {aux_sensor_input_i[TEMP_W-1], aux_sensor_input_i}
                                 : {cold_water_temp_i[TEMP_W-1], cold_water_temp_i};
  assign tank_t = {storage_tank_sensor_input_i[TEMP_W-1], storage_tank_sensor_input_i};
  assign diff_t = ret_t - tank_t;
  assign s_on_t = {1'b0, strat_on_temp_i};
  assign s_hys_t = s_on_t - {1'b0, strat_hyst_i};
  assign s_don_t = {1'b0, don_clamped};
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strat_r <= 1'b0;
    end else if (!strat_enable_i) begin
      strat_r <= 1'b0;
    end else if (strat_diff_mode_i) begin
      if (diff_t > s_don_t) begin
        strat_r <= 1'b1;
      end else if (diff_t < $signed({1'b0, strat_off_delta_i})) begin
        strat_r <= 1'b0;
      end
    end else begin
      if (ret_t > s_on_t) begin
        strat_r <= 1'b1;
      end else if (ret_t < s_hys_t) begin
        strat_r <= 1'b0;
      end
    end
  end
  // Unselected relay held off so the valve never sees two drivers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      relay1_o <= 1'b0;
      relay2_o <= 1'b0;
    end else begin
      relay1_o <= strat_r && strat_relay1_sel_i;
      relay2_o <= strat_r && !strat_relay1_sel_i;
    end
  end
endmodule : csc_ctrl
`default_nettype wire

// *** tb/csc_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_chk
  import csc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic flow_detect_i,
  input wire logic strat_enable_i,
  input wire logic [DUTY_W-1:0] circ_pwm_duty_o,
  input wire logic relay1_o,
  input wire logic relay2_o,
  input wire logic [1:0] demand_state_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_duty_max;
    circ_pwm_duty_o <= DUTY_FULL;
  endproperty
  a_duty_max: assert property (p_duty_max) else $error("duty above full scale");
  property p_relay_one;
    !(relay1_o && relay2_o);
  endproperty
  a_relay_one: assert property (p_relay_one) else $error("both relays energised");
  // Two edges of latency through the relay stage
  property p_strat_off;
    !strat_enable_i [*2] |=> !relay1_o && !relay2_o;
  endproperty
  a_strat_off: assert property (p_strat_off) else $error("relay on while disabled");
  property p_state_legal;
    demand_state_o != 2'b11;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal demand state");
  property p_run_next;
    demand_state_o == CSC_RUN ##1 demand_state_o != CSC_RUN |-> demand_state_o == CSC_PAUSE;
  endproperty
  a_run_next: assert property (p_run_next) else $error("run not followed by pause");
  property p_pause_next;
    demand_state_o == CSC_PAUSE ##1 demand_state_o != CSC_PAUSE |-> demand_state_o == CSC_IDLE;
  endproperty
  a_pause_next: assert property (p_pause_next) else $error("pause left for run");
  property p_idle_next;
    demand_state_o == CSC_IDLE ##1 demand_state_o != CSC_IDLE |-> demand_state_o == CSC_RUN;
  endproperty
  a_idle_next: assert property (p_idle_next) else $error("idle left for pause");
  property p_tap_start;
    $rose(demand_state_o == CSC_RUN) |-> !$past(flow_detect_i, 1) && !$past(flow_detect_i, 2);
  endproperty
  a_tap_start: assert property (p_tap_start) else $error("run started with flow open");
endmodule : csc_ctrl_chk
bind csc_ctrl csc_ctrl_chk u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .flow_detect_i(flow_detect_i),
  .strat_enable_i(strat_enable_i), .circ_pwm_duty_o(circ_pwm_duty_o), .relay1_o(relay1_o),
  .relay2_o(relay2_o), .demand_state_o(demand_state_o));
`default_nettype wire

// *** tb/csc_flow_mdl.sv ***
`timescale 1ns/1ps
`default_nettype none
module csc_flow_mdl (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  output logic flow_o
);
  logic [7:0] cnt_r;
  // Tap open for len_i cycles, then shut; a long opening is no impulse
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
    end else if (go_i) begin
      cnt_r <= len_i;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign flow_o = (cnt_r != 8'h00);
endmodule : csc_flow_mdl
`default_nettype wire

// *** tb/circulation_and_stratification_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module circulation_and_stratification_ctrl_tb_top
  import csc_pkg::*;
();
  logic clock_i, rst_b_i, cen, ten, men, con, den, cext, load, sen, sdif, sext, s1, r1, r2, flow, go;
  logic [TEMP_W-1:0] cw, ax, tk, on_t, doff, s_on, s_hy, s_don, s_doff;
  logic [MIN_W-1:0] run_s, pau_m;
  logic [DUTY_W-1:0] duty_set, duty;
  logic [1:0] st;
  logic [7:0] tlen;
  logic wwr;
  logic [2:0] wday;
  logic [5:0] waddr;
  logic [10:0] mday;
  logic [21:0] wdat;
  int failures, n_checks, k;
  string nms[4] = '{"duty", "relay1", "relay2", "state"};
  // Short counts keep the pause lockout to a few hundred cycles
  csc_ctrl #(.TAP_CYC(20), .SEC_CYCLES(4)) uut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .cold_water_temp_i(cw), .aux_sensor_input_i(ax),
    .storage_tank_sensor_input_i(tk), .flow_detect_i(flow), .minute_of_day_i(mday), .weekday_i(wday),
    .circ_enable_i(cen), .temp_mode_en_i(ten), .time_mode_en_i(men), .continuous_i(con),
    .demand_mode_en_i(den), .circ_ext_sel_i(cext), .circ_on_temp_i(on_t), .circ_off_delta_i(doff),
    .run_sec_i(run_s), .pause_min_i(pau_m), .pump_duty_i(duty_set), .settings_load_i(load),
    .win_wr_i(wwr), .win_addr_i(waddr), .win_data_i(wdat), .strat_enable_i(sen),
    .strat_diff_mode_i(sdif), .strat_ext_sel_i(sext), .strat_relay1_sel_i(s1), .strat_on_temp_i(s_on),
    .strat_hyst_i(s_hy), .strat_on_delta_i(s_don), .strat_off_delta_i(s_doff), .circ_pwm_duty_o(duty),
    .relay1_o(r1), .relay2_o(r2), .demand_state_o(st));
  csc_flow_mdl u_flow (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go), .len_i(tlen), .flow_o(flow));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  function automatic logic [10:0] obs(input int sel);
    case (sel)
      0: return {4'h0, duty};
      1: return {10'h000, r1};
      2: return {10'h000, r2};
      default: return {9'h000, st};
    endcase
  endfunction : obs
  task automatic chk(input int sel, input logic [10:0] exp);
    n_checks++;
    if (obs(sel) !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", nms[sel], exp, obs(sel));
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic wt(input int sel, input logic [10:0] exp, input int n);
    int i;
    i = 0;
    while (i < n && obs(sel) !== exp) begin
      cyc(1);
      i++;
    end
    chk(sel, exp);
    if (obs(sel) !== exp) print_verdict();
  endtask : wt
  task automatic wwin(input logic [5:0] a, input logic [21:0] d);
    @(posedge clock_i);
    {wwr, waddr, wdat} <= {1'b1, a, d};
    @(posedge clock_i);
    wwr <= 1'b0;
    #1;
  endtask : wwin
  task automatic ld(input logic [4:0] m);
    @(posedge clock_i);
    {cen, ten, men, con, den} <= m;
    load <= 1'b1;
    @(posedge clock_i);
    load <= 1'b0;
    #1;
  endtask : ld
  task automatic tap(input logic [7:0] l);
    @(posedge clock_i);
    tlen <= l;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    #1;
  endtask : tap
  initial begin
    failures = 0;
    n_checks = 0;
    rst_b_i = 1'b0;
    {cen, ten, men, con, den, cext, load, sen, sdif, sext, s1, go} = 12'h000;
    {cw, ax, tk, on_t, doff} = {10'h014, 10'h014, 10'h014, 10'h037, 10'h002};
    {s_on, s_hy, s_don, s_doff} = {10'h023, 10'h005, 10'h00A, 10'h006};
    {run_s, pau_m, duty_set, tlen} = {11'h003, 11'h001, 7'h28, 8'h00};
    {wwr, wday, waddr, mday, wdat} = 43'h0;
    cyc(10);
    for (k = 0; k < 4; k++) chk(k, 11'h000);
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    cyc(1);
    for (k = 0; k < 4; k++) chk(k, 11'h000);
    @(posedge clock_i);
    {cen, ten} <= 2'b11;
    cyc(20);
    chk(0, 11'h000);
    $display("test reset done");
    ld(5'b11000);
    wt(0, 11'h028, 30);
    cw <= 10'h03A;
    wt(0, 11'h000, 30);
    cw <= 10'h038;
    cyc(20);
    chk(0, 11'h000);
    cw <= 10'h036;
    wt(0, 11'h028, 30);
    {cext, ax} <= {1'b1, 10'h046};
    ld(5'b11000);
    wt(0, 11'h000, 30);
    cext <= 1'b0;
    ld(5'b11000);
    wt(0, 11'h028, 30);
    {cw, duty_set} <= {10'h046, 7'h64};
    ld(5'b10110);
    wt(0, 11'h064, 30);
    duty_set <= 7'h28;
    ld(5'b10001);
    wt(0, 11'h000, 30);
    $display("test temperature and time done");
    tap(8'h05);
    wt(3, 11'h001, 20);
    cyc(2);
    chk(0, 11'h028);
    tap(8'h05);
    wt(3, 11'h002, 40);
    cyc(2);
    chk(0, 11'h000);
    tap(8'h05);
    cyc(20);
    chk(3, 11'h002);
    ld(5'b10000);
    wt(3, 11'h000, 300);
    tap(8'h1E);
    cyc(60);
    chk(3, 11'h000);
    tap(8'h14);
    wt(3, 11'h001, 40);
    wt(3, 11'h000, 400);
    $display("test demand done");
    {cw, run_s} <= {10'h032, 11'h00A};
    ld(5'b11001);
    cyc(20);
    chk(0, 11'h000);
    tap(8'h05);
    wt(3, 11'h001, 20);
    cw <= 10'h03A;
    wt(3, 11'h002, 10);
    wt(3, 11'h000, 300);
    $display("test temperature and demand done");
    wwin(6'h00, 22'h2962D0);
    for (k = 1; k < 5; k++) wwin(6'(k), 22'h000000);
    ld(5'b10100);
    mday <= 11'h258;
    wt(0, 11'h028, 40);
    mday <= 11'h2D0;
    wt(0, 11'h000, 40);
    mday <= 11'h258;
    ld(5'b11100);
    cyc(20);
    chk(0, 11'h000);
    cw <= 10'h032;
    wt(0, 11'h028, 40);
    mday <= 11'h2D0;
    wt(0, 11'h000, 40);
    ld(5'b10101);
    tap(8'h05);
    wt(0, 11'h028, 40);
    wt(3, 11'h002, 80);
    cyc(2);
    chk(0, 11'h000);
    mday <= 11'h258;
    wt(0, 11'h028, 40);
    wt(3, 11'h000, 300);
    cw <= 10'h03A;
    ld(5'b11101);
    wt(0, 11'h000, 40);
    tap(8'h05);
    cyc(20);
    chk(3, 11'h000);
    mday <= 11'h2D0;
    cyc(20);
    tap(8'h05);
    wt(3, 11'h002, 40);
    wt(3, 11'h000, 300);
    $display("test time windows done");
    {sen, cw} <= {1'b1, 10'h028};
    wt(2, 11'h001, 10);
    chk(1, 11'h000);
    cw <= 10'h020;
    cyc(10);
    chk(2, 11'h001);
    cw <= 10'h01D;
    wt(2, 11'h000, 10);
    {cw, s1} <= {10'h028, 1'b1};
    wt(1, 11'h001, 10);
    {sdif, s1, cw, tk} <= {1'b1, 1'b0, 10'h032, 10'h030};
    cyc(4);
    chk(2, 11'h000);
    chk(1, 11'h000);
    tk <= 10'h01E;
    wt(2, 11'h001, 10);
    tk <= 10'h02E;
    wt(2, 11'h000, 10);
    {sext, ax} <= {1'b1, 10'h050};
    wt(2, 11'h001, 10);
    ax <= 10'h02E;
    wt(2, 11'h000, 10);
    {ax, s_don} <= {10'h047, 10'h03F};
    wt(2, 11'h001, 10);
    sen <= 1'b0;
    wt(2, 11'h000, 10);
    $display("test stratification done");
    print_verdict();
  end
endmodule : circulation_and_stratification_ctrl_tb_top
`default_nettype wire
